// file: include/nioc_pkg.sv
// constants, timing counts and state type for the normal i/o channel
package nioc_pkg;

  // line widths
  localparam int IN_W   = 8;
  localparam int CODE_W = 12;
  localparam int FLD_W  = 6;

  // function code fields: unit in the upper half, function in the lower
  localparam int UNIT_LSB = 6;
  localparam int FUNC_LSB = 0;

  // instruction opcodes kept for reference only, not carried by the command port
  localparam logic [6:0] OP_SELECT = 7'h3d;
  localparam logic [6:0] OP_INPUT  = 7'h3a;

  // clock period and documented times in ns
  localparam int CLK_NS       = 20;
  localparam int SEL_SETUP_NS = 12000;
  localparam int IN_SETUP_NS  = 12000;
  localparam int OUT_SETUP_NS = 16000;
  localparam int FETCH_MAX_NS = 8000;

  // timer width and derived cycle counts
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] SEL_SETUP_CYC =
    TMR_W'((SEL_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] IN_SETUP_CYC =
    TMR_W'((IN_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] OUT_SETUP_CYC = TMR_W'(OUT_SETUP_NS / CLK_NS);
  localparam logic [TMR_W-1:0] FETCH_CYC     = TMR_W'(FETCH_MAX_NS / CLK_NS);
  localparam logic [TMR_W-1:0] TMR_ONE       = TMR_W'(1);

  // reset values of the cable outputs
  localparam logic [CODE_W-1:0] LINES_RST = 12'h000;

  // channel sequencer states
  typedef enum logic [3:0] {
    S_IDLE,
    S_SEL_HOLD,
    S_SEL_SETUP,
    S_SEL_WAIT,
    S_IN_SETUP,
    S_IN_REQ,
    S_IN_STORE,
    S_OUT_SETUP,
    S_OUT_LOAD,
    S_OUT_WAIT,
    S_OUT_FETCH
  } nioc_state_t;

endpackage

// file: include/nioc_buf_if.sv
// word carrier between the channel sequencer and its input buffer
`timescale 1ns/10ps
`default_nettype none
interface nioc_buf_if;
  import nioc_pkg::*;

  logic            wr_valid;
  logic            wr_ready;
  logic [IN_W-1:0] wr_data;
  logic            rd_valid;
  logic            rd_ready;
  logic [IN_W-1:0] rd_data;

  // buffer side
  modport store (
    input  wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );

  // sequencer side
  modport user (
    output wr_valid, wr_data, rd_ready,
    input  wr_ready, rd_valid, rd_data
  );
endinterface
`default_nettype wire

// file: core/nioc_word_buf.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module nioc_word_buf
  import nioc_pkg::*;
(
  // clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rstn_i,
  // buffer ports
  nioc_buf_if.store  bif
);

  logic [IN_W-1:0] mem [2];
  logic [1:0]      vld;
  logic            slot;
  logic            push;
  logic            pop;

  // entry 0 is the head, so the drain side sees flops only
  assign bif.wr_ready = !vld[1];
  assign bif.rd_valid = vld[0];
  assign bif.rd_data  = mem[0];
  assign push         = bif.wr_valid && bif.wr_ready;
  assign pop          = bif.rd_valid && bif.rd_ready;
  // a new word lands behind the head unless the buffer is empty or the head leaves now
  assign slot         = vld[0] && !pop;

  // storage by index, tail moves up when the head is taken
  always_ff @(posedge mclk_i) begin
    if (pop && vld[1]) begin
      mem[0] <= mem[1];
    end
    if (push) begin
      mem[slot] <= bif.wr_data;
    end
  end

  // occupancy flags, full only with both entries held
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      vld <= 2'h0;
    end else if (pop) begin
      vld[0] <= vld[1] || push;
      vld[1] <= 1'b0;
    end else if (push) begin
      vld[slot] <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: core/nioc_channel.sv
// normal i/o channel sequencer: select, word input and word output
// Summary of operation
// - 8 input lines, 12 output lines
// - buffered-line unit selected only when idle
// - select drives code, function ready after 12us
// - output resume drops function ready
// - input setup 12us then input request
// - input ready with word drops request
// - store word, request again if more wanted
// - input ends by no request or disconnect
// - output setup 16us, word with information ready
// - output resume drops information ready
// - next word within 8us after resume clears; the channel waits the full 8us before asking for it
// - output ends by withholding information ready
// - code upper six unit, lower six function
// - disconnect drops request, transfer ends
// - resync every incoming control signal
`timescale 1ns/10ps
`default_nettype none
module nioc_channel
  import nioc_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // command port from the processor
  input  wire logic              sel_start_i,
  input  wire logic [CODE_W-1:0] sel_code_i,
  input  wire logic              sel_buf_unit_i,
  input  wire logic              buf_busy_i,
  input  wire logic              in_start_i,
  input  wire logic              in_more_i,
  input  wire logic              out_start_i,
  input  wire logic              out_end_i,
  input  wire logic              clear_i,
  // output word stream from the processor
  input  wire logic              out_valid_i,
  input  wire logic [IN_W-1:0]   out_data_i,
  output logic                   out_ready_o,
  // input word stream to the processor
  output logic                   in_valid_o,
  output logic [IN_W-1:0]        in_data_o,
  input  wire logic              in_ready_i,
  // status to the processor
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   disc_seen_o,
  // output cable
  output logic [CODE_W-1:0]      out_lines_o,
  output logic                   func_ready_o,
  output logic                   info_ready_o,
  output logic                   master_clear_o,
  input  wire logic              out_resume_i,
  // input cable
  input  wire logic [IN_W-1:0]   in_lines_i,
  input  wire logic              in_rdy_line_i,
  input  wire logic              disconnect_i,
  output logic                   in_request_o
);

  // sequencer state and its shared countdown
  nioc_state_t      state;
  logic [TMR_W-1:0] timer;
  logic             tmr_done;
  // selected unit sits on the buffered lines
  logic             sel_buf;
  // first and second resync stages, only the second is read
  logic [IN_W-1:0]  data_m;
  logic [IN_W-1:0]  data_s;
  logic             resume_m;
  logic             resume_s;
  logic             rdy_m;
  logic             rdy_s;
  logic             disc_m;
  logic             disc_s;

  nioc_buf_if bif ();

  // input word buffer, drained by the processor with back-pressure
  // a slow reader stalls the cable instead of losing a word
  nioc_word_buf u_buf (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .bif    (bif)
  );

  // buffer drain side faces the processor directly
  assign in_valid_o   = bif.rd_valid;
  assign in_data_o    = bif.rd_data;
  assign bif.rd_ready = in_ready_i;

  // last count of the shared countdown
  assign tmr_done     = (timer == TMR_ONE);

  // two-stage resync of every cable input
  // unit strobes run on their own timing, so stage one is never read
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      resume_m <= 1'b0;
      resume_s <= 1'b0;
      rdy_m    <= 1'b0;
      rdy_s    <= 1'b0;
      disc_m   <= 1'b0;
      disc_s   <= 1'b0;
      data_m   <= '0;
      data_s   <= '0;
    end else begin
      resume_m <= out_resume_i;
      resume_s <= resume_m;
      rdy_m    <= in_rdy_line_i;
      rdy_s    <= rdy_m;
      disc_m   <= disconnect_i;
      disc_s   <= disc_m;
      data_m   <= in_lines_i;
      data_s   <= data_m;
    end
  end

  // master clear line follows the processor clear request
  // units clear themselves while this line stands high
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      master_clear_o <= 1'b0;
    end else begin
      master_clear_o <= clear_i;
    end
  end

  // channel sequencer, cable strobes and status
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state        <= S_IDLE;
      timer        <= '0;
      sel_buf      <= 1'b0;
      out_lines_o  <= LINES_RST;
      func_ready_o <= 1'b0;
      info_ready_o <= 1'b0;
      in_request_o <= 1'b0;
      out_ready_o  <= 1'b0;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      disc_seen_o  <= 1'b0;
      bif.wr_valid <= 1'b0;
      bif.wr_data  <= '0;
    end else begin
      done_o       <= 1'b0;
      bif.wr_valid <= 1'b0;
      // one state per step of the select, input and output sequences
      case (state)
        // take one command, select before input before output
        S_IDLE: begin
          if (sel_start_i) begin
            out_lines_o <= sel_code_i;
            sel_buf     <= sel_buf_unit_i;
            busy_o      <= 1'b1;
            state       <= S_SEL_HOLD;
          end else if (in_start_i) begin
            timer       <= IN_SETUP_CYC;
            busy_o      <= 1'b1;
            disc_seen_o <= 1'b0;
            state       <= S_IN_SETUP;
          end else if (out_start_i) begin
            timer       <= OUT_SETUP_CYC;
            busy_o      <= 1'b1;
            state       <= S_OUT_SETUP;
          end
        end

        // buffered-line unit waits for the buffer channel to go quiet
        S_SEL_HOLD: begin
          if (!(sel_buf && buf_busy_i) && !resume_s) begin
            timer <= SEL_SETUP_CYC;
            state <= S_SEL_SETUP;
          end
        end

        // count out the code setup, then raise function ready
        S_SEL_SETUP: begin
          if (tmr_done) begin
            func_ready_o <= 1'b1;
            state        <= S_SEL_WAIT;
          end else begin
            timer <= timer - TMR_ONE;
          end
        end

        // code held on the lines until the unit answers
        S_SEL_WAIT: begin
          if (resume_s) begin
            func_ready_o <= 1'b0;
            busy_o       <= 1'b0;
            done_o       <= 1'b1;
            state        <= S_IDLE;
          end
        end

        // no request while a previous ready is still up or buffer full
        S_IN_SETUP: begin
          if (tmr_done) begin
            if (!rdy_s && bif.wr_ready) begin
              in_request_o <= 1'b1;
              state        <= S_IN_REQ;
            end
          end else begin
            timer <= timer - TMR_ONE;
          end
        end

        // ready wins over disconnect when both arrive together
        S_IN_REQ: begin
          if (rdy_s) begin
            bif.wr_valid <= 1'b1;
            bif.wr_data  <= data_s;
            in_request_o <= 1'b0;
            state        <= S_IN_STORE;
          end else if (disc_s) begin
            in_request_o <= 1'b0;
            disc_seen_o  <= 1'b1;
            busy_o       <= 1'b0;
            done_o       <= 1'b1;
            state        <= S_IDLE;
          end
        end

        // stop at once when no more is wanted, else wait for the unit to drop ready and ask again
        S_IN_STORE: begin
          if (!in_more_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state  <= S_IDLE;
          end else if (!rdy_s && !bif.wr_valid && bif.wr_ready) begin
            in_request_o <= 1'b1;
            state        <= S_IN_REQ;
          end
        end

        // output setup count, then ask the processor for a word
        S_OUT_SETUP: begin
          if (tmr_done) begin
            out_ready_o <= 1'b1;
            state       <= S_OUT_LOAD;
          end else begin
            timer <= timer - TMR_ONE;
          end
        end

        // take one word, or finish without raising information ready
        S_OUT_LOAD: begin
          if (out_valid_i) begin
            out_lines_o  <= {{(CODE_W-IN_W){1'b0}}, out_data_i};
            info_ready_o <= 1'b1;
            out_ready_o  <= 1'b0;
            state        <= S_OUT_WAIT;
          end else if (out_end_i) begin
            out_ready_o <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b1;
            state       <= S_IDLE;
          end
        end

        // word held on the lines until the unit answers
        S_OUT_WAIT: begin
          if (resume_s) begin
            info_ready_o <= 1'b0;
            timer        <= FETCH_CYC;
            state        <= S_OUT_FETCH;
          end
        end

        // fetch gap counts only once the unit has let go of resume
        S_OUT_FETCH: begin
          if (!resume_s) begin
            if (tmr_done) begin
              out_ready_o <= 1'b1;
              state       <= S_OUT_LOAD;
            end else begin
              timer <= timer - TMR_ONE;
            end
          end
        end

        // unused encodings fall back to idle
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // the cable lines are loaded only in idle or in the load state,
  // where function ready and information ready are both low,
  // so a unit never sees the lines move under a ready flag

endmodule
`default_nettype wire

// file: testbench/nioc_checker.sv
// cable handshake and timing assertions for the channel
`timescale 1ns/10ps
`default_nettype none
module nioc_checker
  import nioc_pkg::*;
(
  // clock and reset
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  // watched ports
  input wire logic              busy_o,
  input wire logic              out_ready_o,
  input wire logic [CODE_W-1:0] out_lines_o,
  input wire logic              func_ready_o,
  input wire logic              info_ready_o,
  input wire logic              out_resume_i,
  input wire logic              in_request_o,
  input wire logic              in_rdy_line_i,
  input wire logic              disconnect_i
);
  localparam int SET_MIN = 590;
  localparam int OUT_MIN = 790;
  logic [15:0] cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // cycles spent busy on the current command
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !busy_o) begin
      cnt <= 16'h0000;
    end else if (cnt != 16'hffff) begin
      cnt <= cnt + 16'h0001;
    end
  end
  setup_time_a: assert property (($rose(func_ready_o) || $rose(in_request_o)) |-> cnt >= SET_MIN)
    else $error("setup too short");
  out_setup_a: assert property ($rose(out_ready_o) |-> cnt >= OUT_MIN)
    else $error("output setup too short");
  func_drop_a: assert property (func_ready_o && out_resume_i |-> ##[1:3] !func_ready_o)
    else $error("function ready stuck");
  info_drop_a: assert property (info_ready_o && out_resume_i |-> ##[1:3] !info_ready_o)
    else $error("information ready stuck");
  req_drop_a: assert property (in_request_o && in_rdy_line_i |-> ##[1:3] !in_request_o)
    else $error("request stuck after ready");
  disc_drop_a: assert property (in_request_o && disconnect_i |-> ##[1:3] !in_request_o)
    else $error("request stuck after disconnect");
  resync_a: assert property ($rose(in_rdy_line_i) && in_request_o |=> in_request_o)
    else $error("ready acted on unsynced");
  line_hold_a: assert property ((func_ready_o || info_ready_o) && $past(func_ready_o || info_ready_o)
    |-> $stable(out_lines_o))
    else $error("output lines moved");
  // main scenarios
  cover property ($fell(func_ready_o));
  cover property (in_request_o && disconnect_i);
  cover property ($fell(info_ready_o));
endmodule
bind nioc_channel nioc_checker u_chk (.mclk_i, .rstn_i, .busy_o, .out_ready_o, .out_lines_o,
  .func_ready_o, .info_ready_o, .out_resume_i, .in_request_o, .in_rdy_line_i, .disconnect_i);
`default_nettype wire

// file: testbench/nioc_unit_model.sv
// behavioural peripheral unit on the far side of the cables, one unit only
`timescale 1ns/10ps
`default_nettype none
module nioc_unit_model (
  // clock, reset and pacing
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  dly_i,
  input wire logic [7:0]  nw_i,
  // output cable
  input wire logic [11:0] lines_i,
  input wire logic        fready_i,
  input wire logic        iready_i,
  output logic            resume_o,
  output logic [11:0]     cap_o,
  // input cable
  input wire logic        req_i,
  output logic            rdy_o,
  output logic            disc_o,
  output logic [7:0]      data_o
);
  logic [7:0] oc, ic, sent;
  // resume after own pace (>=2us), drop when flags fall
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || (!fready_i && !iready_i)) begin
      resume_o <= 1'b0;
      oc <= 8'h00;
    end else if (!resume_o) begin
      oc <= oc + 8'h01;
      if (oc == dly_i) begin
        resume_o <= 1'b1;
        cap_o <= lines_i;
      end
    end
  end
  // word per request, then disconnect; released lines pull to 0
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !req_i) begin
      rdy_o <= 1'b0;
      disc_o <= 1'b0;
      data_o <= 8'h00;
      ic <= 8'h00;
    end else if (!rdy_o && !disc_o) begin
      ic <= ic + 8'h01;
      if (ic == 8'h00 && sent != nw_i) data_o <= 8'h40 + sent;
      if (ic == dly_i) begin
        rdy_o <= (sent != nw_i);
        disc_o <= (sent == nw_i);
        sent <= sent + 8'h01;
      end
    end
    if (!rstn_i || fready_i) sent <= 8'h00;
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the normal i/o channel
`timescale 1ns/10ps
`default_nettype none
module tb;
  import nioc_pkg::*;
  logic mclk_i, rstn_i, sel_start_i, sel_buf_unit_i, buf_busy_i, in_start_i, in_more_i;
  logic out_start_i, out_end_i, clear_i, out_valid_i, in_ready_i, out_resume_i;
  logic out_ready_o, in_valid_o, busy_o, done_o, disc_seen_o, func_ready_o, info_ready_o;
  logic master_clear_o, in_request_o, in_rdy_line_i, disconnect_i;
  logic [11:0] sel_code_i, out_lines_o, cap;
  logic [7:0] out_data_i, in_data_o, in_lines_i, m_dly, m_nw;
  int errors, tests_run;
  nioc_channel DUT (.mclk_i, .rstn_i, .sel_start_i, .sel_code_i, .sel_buf_unit_i, .buf_busy_i,
    .in_start_i, .in_more_i, .out_start_i, .out_end_i, .clear_i, .out_valid_i, .out_data_i,
    .out_ready_o, .in_valid_o, .in_data_o, .in_ready_i, .busy_o, .done_o, .disc_seen_o,
    .out_lines_o, .func_ready_o, .info_ready_o, .master_clear_o, .out_resume_i, .in_lines_i,
    .in_rdy_line_i, .disconnect_i, .in_request_o);
  nioc_unit_model u_unit (.mclk_i, .rstn_i, .dly_i(m_dly), .nw_i(m_nw), .lines_i(out_lines_o),
    .fready_i(func_ready_o), .iready_i(info_ready_o), .resume_o(out_resume_i), .cap_o(cap),
    .req_i(in_request_o), .rdy_o(in_rdy_line_i), .disc_o(disconnect_i), .data_o(in_lines_i));
  // 50 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one negedge step of a bounded wait
  task automatic step(inout int n, inout logic dn);
    @(negedge mclk_i);
    n++;
    if (done_o === 1'b1) dn = 1'b1;
    if (n > 9000) begin
      errors++;
      $display("BAD wait limit exp done got none after %0d cycles", n);
      conclude();
    end
  endtask
  // select a unit, a buffered one held off while the buffer channel is busy
  task automatic t_select(input logic [11:0] code, input logic bu);
    int n;
    logic dn;
    n = 0;
    dn = 1'b0;
    @(posedge mclk_i);
    sel_code_i <= code;
    sel_buf_unit_i <= bu;
    buf_busy_i <= bu;
    sel_start_i <= 1'b1;
    @(posedge mclk_i);
    sel_start_i <= 1'b0;
    if (bu) begin
      repeat (700) @(negedge mclk_i);
      check("func ready held", 12'h000, {11'h000, func_ready_o});
      @(posedge mclk_i);
      buf_busy_i <= 1'b0;
    end
    while (!dn) step(n, dn);
    check("unit code", code, cap);
    check("busy after select", 12'h000, {11'h000, busy_o});
  endtask
  // input run with the reader stalled first, then drained
  task automatic t_input(input logic [7:0] nw, input logic more, input int nexp, input logic de);
    int n, k;
    logic dn;
    n = 0;
    k = 0;
    dn = 1'b0;
    @(posedge mclk_i);
    m_nw <= nw;
    in_more_i <= more;
    in_start_i <= 1'b1;
    @(posedge mclk_i);
    in_start_i <= 1'b0;
    while (k < nexp || !dn) begin
      step(n, dn);
      if (n == 1500) check("request when full", 12'h000, {11'h000, in_request_o});
      if (in_valid_o === 1'b1 && in_ready_i === 1'b1) begin
        check("input word", {4'h0, 8'h40 + k[7:0]}, {4'h0, in_data_o});
        k++;
      end
      @(posedge mclk_i);
      in_ready_i <= (n >= 1500) && (k < nexp || !dn);
    end
    @(negedge mclk_i);
    check("words left", 12'h000, {11'h000, in_valid_o});
    check("word count", 12'(nexp), 12'(k));
    check("disconnect seen", {11'h000, de}, {11'h000, disc_seen_o});
    check("request after end", 12'h000, {11'h000, in_request_o});
  endtask
  // output of nw words, then end by withholding the next
  task automatic t_output(input int nw);
    int n, k, s;
    logic dn, pf, tk;
    n = 0;
    k = 0;
    s = 0;
    dn = 1'b0;
    pf = 1'b0;
    @(posedge mclk_i);
    out_start_i <= 1'b1;
    out_valid_i <= 1'b1;
    out_data_i <= 8'ha0;
    @(posedge mclk_i);
    out_start_i <= 1'b0;
    while (!dn) begin
      step(n, dn);
      if (info_ready_o === 1'b1 && !pf) begin
        check("output word", {4'h0, 8'ha0 + s[7:0]}, out_lines_o);
        s++;
      end
      pf = info_ready_o;
      tk = (out_valid_i === 1'b1 && out_ready_o === 1'b1);
      @(posedge mclk_i);
      if (tk) begin
        k++;
        out_data_i <= 8'ha0 + 8'(k);
        out_valid_i <= (k < nw);
        out_end_i <= (k >= nw);
      end
    end
    out_end_i <= 1'b0;
    check("words sent", 12'(nw), 12'(s));
    check("info ready after end", 12'h000, {11'h000, info_ready_o});
    check("unit captured", {4'h0, 8'ha0 + 8'(nw - 1)}, cap);
  endtask
  // master clear follows the clear request one cycle later
  task automatic t_clear();
    @(posedge mclk_i);
    clear_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    check("master clear on", 12'h001, {11'h000, master_clear_o});
    @(posedge mclk_i);
    clear_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    check("master clear off", 12'h000, {11'h000, master_clear_o});
  endtask
  // reset, then select/input/output scenarios
  initial begin
    errors = 0;
    tests_run = 0;
    {rstn_i, sel_start_i, sel_buf_unit_i, buf_busy_i, in_start_i, in_more_i} = 6'h00;
    {out_start_i, out_end_i, clear_i, out_valid_i, in_ready_i} = 5'h00;
    sel_code_i = 12'h000;
    out_data_i = 8'h00;
    m_dly = 8'h64;
    m_nw = 8'h00;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_select(12'h5c3, 1'b0);
    t_input(8'h03, 1'b1, 3, 1'b1);
    t_select(12'h2a7, 1'b1);
    t_input(8'h05, 1'b0, 1, 1'b0);
    m_dly <= 8'hc8;
    t_select(12'h3c1, 1'b0);
    t_output(3);
    t_clear();
    conclude();
  end
endmodule
`default_nettype wire
